// ### hdl/spc_port_top.sv
// top-level port conditioning: resets, channel ports, external bus boundary
`timescale 1ns/1ps
module spc_port_top
    import spc_pkg::*;
#(
    parameter int NUM_CH = SPC_MAX_CH
) (
    input  wire logic                  clk,
    input  wire logic                  arst_n,
    input  wire logic                  clkEn,
    input  wire logic                  wdtRstReq,
    input  wire logic                  ocdRstReq,
    output logic                       rstnWdt,
    output logic                       rstnOcd,
    input  wire logic [SPC_MAX_CH-1:0] chOutReq,
    output logic      [SPC_MAX_CH-1:0] chOut,
    input  wire logic [SPC_MAX_CH-1:0] chIn     = {SPC_MAX_CH{SPC_PULL_DOWN}},
    output logic      [SPC_MAX_CH-1:0] chanIn,
    input  wire logic                  extSelN  = SPC_PULL_UP,
    output logic                       extSel,
    input  wire logic                  reqValid,
    input  wire logic                  reqWrite,
    input  wire logic [SPC_ADR_W-1:0]  reqAddr,
    input  wire logic [SPC_DAT_W-1:0]  reqWdata,
    input  wire logic [SPC_SEL_W-1:0]  reqSel,
    input  wire logic [SPC_TAG_W-1:0]  reqTag,
    output logic                       reqReady,
    output logic                       rspValid,
    output logic                       rspErr,
    output logic      [SPC_DAT_W-1:0]  rspData,
    output logic      [SPC_ADR_W-1:0]  xbusAdr,
    output logic      [SPC_DAT_W-1:0]  xbusDat,
    output logic      [SPC_TAG_W-1:0]  xbusTag,
    output logic                       xbusWe,
    output logic      [SPC_SEL_W-1:0]  xbusSel,
    output logic                       xbusStb,
    output logic                       xbusCyc,
    input  wire logic [SPC_DAT_W-1:0]  xbusRdat = {SPC_DAT_W{SPC_PULL_DOWN}},
    input  wire logic                  xbusAck  = SPC_PULL_DOWN,
    input  wire logic                  xbusErr  = SPC_PULL_DOWN
);

    localparam logic [SPC_MAX_CH-1:0] CH_MASK = spc_chan_mask(NUM_CH);

    ////////////////////////////////////////////////////////////////////////////
    // input synchronisation

    spc_sync_if #(.WIDTH(SPC_SYNC_W)) syncBus ();

    // open inputs default to their pull level via port defaults
    spc_sync_bank #(
        .WIDTH   (SPC_SYNC_W),
        .RST_VAL (SPC_SYNC_RST)
    ) u_sync (
        .clk    (clk),
        .arst_n (arst_n),
        .clkEn  (clkEn),
        .din    ({extSelN, xbusErr, xbusAck, xbusRdat, chIn}),
        .q      (syncBus.src)
    );

    logic [SPC_MAX_CH-1:0] chInS;
    logic [SPC_DAT_W-1:0]  rdatS;
    logic                  ackS;
    logic                  errS;
    logic                  selNS;

    assign chInS = syncBus.data[SPC_POS_CH +: SPC_MAX_CH];
    assign rdatS = syncBus.data[SPC_POS_RDAT +: SPC_DAT_W];
    assign ackS  = syncBus.data[SPC_POS_ACK];
    assign errS  = syncBus.data[SPC_POS_ERR];
    assign selNS = syncBus.data[SPC_POS_SELN];

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic

    spc_bus_state_t        state;
    spc_bus_state_t        next_state;
    logic                  next_rstnWdt;
    logic                  next_rstnOcd;
    logic [SPC_MAX_CH-1:0] next_chOut;
    logic [SPC_MAX_CH-1:0] next_chanIn;
    logic                  next_extSel;
    logic                  next_reqReady;
    logic                  next_rspValid;
    logic                  next_rspErr;
    logic [SPC_DAT_W-1:0]  next_rspData;
    logic [SPC_ADR_W-1:0]  next_xbusAdr;
    logic [SPC_DAT_W-1:0]  next_xbusDat;
    logic [SPC_TAG_W-1:0]  next_xbusTag;
    logic                  next_xbusWe;
    logic [SPC_SEL_W-1:0]  next_xbusSel;
    logic                  next_xbusStb;
    logic                  next_xbusCyc;

    always_comb begin
        next_state    = state;
        next_rstnWdt  = rstnWdt;
        next_rstnOcd  = rstnOcd;
        next_chOut    = chOut;
        next_chanIn   = chanIn;
        next_extSel   = extSel;
        next_reqReady = reqReady;
        next_rspValid = rspValid;
        next_rspErr   = rspErr;
        next_rspData  = rspData;
        next_xbusAdr  = xbusAdr;
        next_xbusDat  = xbusDat;
        next_xbusTag  = xbusTag;
        next_xbusWe   = xbusWe;
        next_xbusSel  = xbusSel;
        next_xbusStb  = xbusStb;
        next_xbusCyc  = xbusCyc;
        if (clkEn) begin
            next_rstnWdt  = !wdtRstReq;
            next_rstnOcd  = !ocdRstReq;
            next_chOut    = chOutReq & CH_MASK;
            next_chanIn   = chInS & CH_MASK;
            next_extSel   = !selNS;
            next_rspValid = 1'b0;
            next_xbusStb  = 1'b0;
            case (state)
                SPC_IDLE: begin
                    if (reqValid && reqReady) begin
                        next_xbusAdr  = reqAddr;
                        next_xbusDat  = reqWdata;
                        next_xbusTag  = reqTag;
                        next_xbusWe   = reqWrite;
                        next_xbusSel  = reqSel;
                        next_xbusStb  = 1'b1;
                        next_xbusCyc  = 1'b1;
                        next_reqReady = 1'b0;
                        next_state    = SPC_BUSY;
                    end else begin
                        next_reqReady = 1'b1;
                    end
                end
                SPC_BUSY: begin
                    // cycle stays up until a synchronised answer
                    if (ackS || errS) begin
                        next_xbusCyc  = 1'b0;
                        next_rspValid = 1'b1;
                        next_rspErr   = errS;
                        next_rspData  = rdatS;
                        next_state    = SPC_DRAIN;
                    end
                end
                SPC_DRAIN: begin
                    // a held answer still sits in the synchroniser; wait it out
                    if (!ackS && !errS) begin
                        next_reqReady = 1'b1;
                        next_state    = SPC_IDLE;
                    end
                end
                default: begin
                    next_xbusCyc  = 1'b0;
                    next_reqReady = 1'b0;
                    next_state    = SPC_DRAIN;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state    <= SPC_IDLE;
            rstnWdt  <= SPC_RSTN_ACTIVE;
            rstnOcd  <= SPC_RSTN_ACTIVE;
            chOut    <= '0;
            chanIn   <= '0;
            extSel   <= 1'b0;
            reqReady <= 1'b0;
            rspValid <= 1'b0;
            rspErr   <= 1'b0;
            rspData  <= '0;
            xbusAdr  <= '0;
            xbusDat  <= '0;
            xbusTag  <= '0;
            xbusWe   <= 1'b0;
            xbusSel  <= '0;
            xbusStb  <= 1'b0;
            xbusCyc  <= 1'b0;
        end else begin
            state    <= next_state;
            rstnWdt  <= next_rstnWdt;
            rstnOcd  <= next_rstnOcd;
            chOut    <= next_chOut;
            chanIn   <= next_chanIn;
            extSel   <= next_extSel;
            reqReady <= next_reqReady;
            rspValid <= next_rspValid;
            rspErr   <= next_rspErr;
            rspData  <= next_rspData;
            xbusAdr  <= next_xbusAdr;
            xbusDat  <= next_xbusDat;
            xbusTag  <= next_xbusTag;
            xbusWe   <= next_xbusWe;
            xbusSel  <= next_xbusSel;
            xbusStb  <= next_xbusStb;
            xbusCyc  <= next_xbusCyc;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    sequence en3_s;
        clkEn [*3];
    endsequence

    sequence answered_s;
        state == SPC_BUSY && clkEn && (ackS || errS);
    endsequence

    sequence start_s;
        state == SPC_IDLE && clkEn && reqValid && reqReady;
    endsequence

    freeze_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
        !clkEn |=> $stable(state) && $stable(xbusCyc) && $stable(chOut) && $stable(rstnWdt))
        else $error("state moved while clock enable low");

    rst_release_a: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(arst_n) |-> !xbusCyc && !rspValid && rstnWdt == SPC_RSTN_ACTIVE)
        else $error("outputs not at reset values after release");

    wdt_reset_a: assert property (@(posedge clk) disable iff (!arst_n)
        arst_n && clkEn |=> rstnWdt == !$past(wdtRstReq))
        else $error("watchdog reset output wrong");

    ocd_reset_a: assert property (@(posedge clk) disable iff (!arst_n)
        arst_n && clkEn && ocdRstReq |=> !rstnOcd)
        else $error("debugger reset output not asserted");

    unused_out_a: assert property (@(posedge clk) disable iff (!arst_n)
        (chOut & ~CH_MASK) == '0)
        else $error("unused output channel not zero");

    chan_in_a: assert property (@(posedge clk) disable iff (!arst_n)
        arst_n ##0 en3_s |=> chanIn == ($past(chIn, 3) & CH_MASK))
        else $error("channel input not synchronised and masked");

    out_reg_a: assert property (@(posedge clk) disable iff (!arst_n)
        arst_n && clkEn |=> chOut == ($past(chOutReq) & CH_MASK))
        else $error("channel output not registered");

    write_enable_a: assert property (@(posedge clk) disable iff (!arst_n)
        start_s |=> xbusCyc && xbusStb && xbusWe == $past(reqWrite))
        else $error("write enable does not match request");

    cyc_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
        state == SPC_BUSY && !(clkEn && (ackS || errS)) |=> xbusCyc)
        else $error("cycle dropped before answer");

    cyc_end_a: assert property (@(posedge clk) disable iff (!arst_n)
        answered_s |=> !xbusCyc && rspValid && rspErr == $past(errS))
        else $error("transfer not closed after answer");

endmodule : spc_port_top

// ### hdl/spc_pkg.sv
// constants and types shared by the port conditioning block
package spc_pkg;

    localparam int SPC_MAX_CH  = 16;
    localparam int SPC_ADR_W   = 32;
    localparam int SPC_DAT_W   = 32;
    localparam int SPC_SEL_W   = 4;
    localparam int SPC_TAG_W   = 3;

    localparam logic SPC_PULL_DOWN   = 1'b0;
    localparam logic SPC_PULL_UP     = 1'b1;
    localparam logic SPC_RSTN_ACTIVE = 1'b0;

    // layout of the synchronised input vector
    localparam int SPC_POS_CH   = 0;
    localparam int SPC_POS_RDAT = SPC_POS_CH + SPC_MAX_CH;
    localparam int SPC_POS_ACK  = SPC_POS_RDAT + SPC_DAT_W;
    localparam int SPC_POS_ERR  = SPC_POS_ACK + 1;
    localparam int SPC_POS_SELN = SPC_POS_ERR + 1;
    localparam int SPC_SYNC_W   = SPC_POS_SELN + 1;

    localparam logic [SPC_SYNC_W-1:0] SPC_SYNC_RST = {
        SPC_PULL_UP, SPC_PULL_DOWN, SPC_PULL_DOWN,
        {SPC_DAT_W{SPC_PULL_DOWN}}, {SPC_MAX_CH{SPC_PULL_DOWN}}};

    typedef enum logic [2:0] {
        SPC_IDLE  = 3'b001,
        SPC_BUSY  = 3'b010,
        SPC_DRAIN = 3'b100
    } spc_bus_state_t;

    function automatic logic [SPC_MAX_CH-1:0] spc_chan_mask(input int n);
        logic [SPC_MAX_CH-1:0] m;
        m = '0;
        for (int i = 0; i < SPC_MAX_CH; i++) begin
            m[i] = (i < n);
        end
        return m;
    endfunction : spc_chan_mask

endpackage : spc_pkg

// ### hdl/spc_sync_if.sv
// carrier for synchronised input bits between the sync bank and the top
`timescale 1ns/1ps
interface spc_sync_if #(parameter int WIDTH = 1);
    logic [WIDTH-1:0] data;
    modport src (output data);
    modport dst (input data);
endinterface : spc_sync_if

// ### hdl/spc_sync_bank.sv
// two-stage synchroniser bank with per-bit idle levels
`timescale 1ns/1ps
module spc_sync_bank #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic             clkEn,
    input  wire logic [WIDTH-1:0] din,
    spc_sync_if.src               q
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_stage2;

    // stage1 feeds stage2 only, never any logic
    always_comb begin
        next_stage1 = stage1;
        next_stage2 = stage2;
        if (clkEn) begin
            next_stage1 = din;
            next_stage2 = stage1;
        end
    end

    // reset to the idle level so nothing spurious leaves reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stage1 <= RST_VAL;
            stage2 <= RST_VAL;
        end else begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
        end
    end

    assign q.data = stage2;

endmodule : spc_sync_bank

// ### test/spc_bus_slave.sv
// bus slave model standing on the far side of the external bus port
`timescale 1ns/1ps
module spc_bus_slave
    import spc_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 arst_n,
    input  wire logic                 stb,
    input  wire logic                 we,
    input  wire logic [SPC_DAT_W-1:0] wdat,
    input  wire logic                 errMode,
    input  wire logic [3:0]           waitCyc,
    output logic                      ack,
    output logic                      err,
    output logic      [SPC_DAT_W-1:0] rdat // own wire apart from wdat, no shared pad
);
    logic [SPC_DAT_W-1:0] mem;
    logic [3:0]           cnt;
    logic                 busy;
    ////////////////////////////////////////////////////////////////////////////////
    // rdat toggles outside the answer, so stale read data never looks valid
    // answers leave from flops: the extra boundary stage
    always @(posedge clk or negedge arst_n) begin
        ack <= 1'b0;
        err <= 1'b0;
        rdat <= ~rdat;
        if (!arst_n) begin
            busy <= 1'b0;
            cnt <= 4'h0;
            mem <= '0;
            rdat <= '0;
        end else if (busy) begin
            if (cnt == 4'h0) begin
                busy <= 1'b0;
                ack <= !errMode;
                err <= errMode;
                rdat <= mem;
            end else begin
                cnt <= cnt - 4'h1;
            end
        end else if (stb) begin
            busy <= 1'b1;
            cnt <= waitCyc;
            if (we) begin
                mem <= wdat;
            end
        end
    end
endmodule : spc_bus_slave

// ### test/tb_spc_port_top.sv
// self-checking bench for the port conditioning block
`timescale 1ns/1ps
module tb_spc_port_top;
    import spc_pkg::*;
    localparam int NCH = 4;
    logic                 clk = 1'b0, arst_n = 1'b0, wdtRstReq = 1'b0, ocdRstReq = 1'b0;
    logic [15:0]          chOutReq = 16'h0, chIn = 16'h0;
    logic                 extSelN = 1'b1, reqValid = 1'b0, reqWrite = 1'b0;
    logic [31:0]          reqAddr = 32'h0, reqWdata = 32'h0;
    logic [3:0]           reqSel = 4'h0, waitCyc = 4'h0;
    logic [2:0]           reqTag = 3'h0;
    logic                 errMode = 1'b0, clkEn = 1'b1;
    logic                 rstnWdt, rstnOcd, extSel, reqReady, rspValid, rspErr;
    logic                 xbusWe, xbusStb, xbusCyc, xbusAck, xbusErr;
    logic [15:0]          chOut, chanIn;
    logic [31:0]          rspData, xbusAdr, xbusDat, xbusRdat;
    logic [3:0]           xbusSel;
    logic [2:0]           xbusTag;
    int                   fails = 0, total_checks = 0, cycles = 0;
    ////////////////////////////////////////////////////////////////////////////////
    spc_port_top #(.NUM_CH(NCH)) u_dut (
        .clk, .arst_n, .clkEn, .wdtRstReq, .ocdRstReq, .rstnWdt, .rstnOcd,
        .chOutReq, .chOut, .chIn, .chanIn, .extSelN, .extSel, .reqValid, .reqWrite,
        .reqAddr, .reqWdata, .reqSel, .reqTag, .reqReady, .rspValid, .rspErr, .rspData,
        .xbusAdr, .xbusDat, .xbusTag, .xbusWe, .xbusSel, .xbusStb, .xbusCyc, .xbusRdat,
        .xbusAck, .xbusErr);
    spc_bus_slave u_slave (.clk, .arst_n, .stb(xbusStb), .we(xbusWe), .wdat(xbusDat),
        .errMode, .waitCyc, .ack(xbusAck), .err(xbusErr), .rdat(xbusRdat));
    initial begin
        forever #2 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic stop_test();
        if (fails == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            stop_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // reset mid-run lands on a clock edge and acts before the next one, then each request drives its own output
    task automatic t_reset();
        @(posedge clk);
        arst_n <= 1'b0;
        #1;
        check("rstnOcd", 32'(rstnOcd), 32'h0);
        check("reqReady", 32'(reqReady), 32'h0);
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        wdtRstReq <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check("rstnWdt", 32'(rstnWdt), 32'h0);
        check("rstnOcd", 32'(rstnOcd), 32'h1);
        @(posedge clk);
        wdtRstReq <= 1'b0;
        ocdRstReq <= 1'b1;
        #1;
        check("rstnOcd", 32'(rstnOcd), 32'h1);
        @(posedge clk);
        ocdRstReq <= 1'b0;
        #1;
        check("rstnWdt", 32'(rstnWdt), 32'h1);
        check("rstnOcd", 32'(rstnOcd), 32'h0);
    endtask : t_reset
    // only the low NCH channels pass; upper output bits stay zero
    task automatic t_chan();
        @(posedge clk);
        chOutReq <= 16'hffff;
        chIn <= 16'hfff5;
        extSelN <= 1'b0;
        @(posedge clk);
        #1;
        check("chOut", 32'(chOut), 32'((16'h1 << NCH) - 16'h1));
        @(posedge clk);
        #1;
        check("chanIn early", 32'(chanIn), 32'h0);
        @(posedge clk);
        #1;
        check("chanIn", 32'(chanIn), 32'h5);
        check("extSel", 32'(extSel), 32'h1);
    endtask : t_chan
    // enable low holds chOut and rstnWdt, then both resume on the first enabled edge
    task automatic t_freeze();
        @(posedge clk);
        clkEn <= 1'b0;
        chOutReq <= 16'h0003;
        wdtRstReq <= 1'b1;
        repeat (2) @(posedge clk);
        clkEn <= 1'b1;
        #1;
        check("chOut frozen", 32'(chOut), 32'h000f);
        check("rstnWdt frozen", 32'(rstnWdt), 32'h1);
        @(posedge clk);
        wdtRstReq <= 1'b0;
        #1;
        check("chOut resumed", 32'(chOut), 32'h0003);
        check("rstnWdt resumed", 32'(rstnWdt), 32'h0);
    endtask : t_freeze
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       input logic e, input logic [3:0] w, output logic [31:0] rd);
        int   n;
        logic held;
        logic took;
        n = 0;
        held = 1'b1;
        took = 1'b0;
        @(posedge clk);
        reqValid <= 1'b1;
        reqWrite <= wr;
        reqAddr <= a;
        reqWdata <= d;
        reqSel <= 4'h5;
        reqTag <= 3'h6;
        errMode <= e;
        waitCyc <= w;
        // ready is read settled, mid-cycle, before the edge that takes the request
        do begin
            @(negedge clk);
            took = (reqReady === 1'b1);
            @(posedge clk);
            n++;
        end while (!took && n < 50);
        reqValid <= 1'b0;
        #1;
        check("xbusWe", 32'(xbusWe), 32'(wr));
        check("xbusAdr", xbusAdr, a);
        check("xbusSel", 32'(xbusSel), 32'h5);
        check("xbusTag", 32'(xbusTag), 32'h6);
        check("xbusStb start", 32'(xbusStb), 32'h1);
        if (wr) begin
            check("xbusDat", xbusDat, d);
        end
        @(posedge clk);
        #1;
        check("xbusStb", 32'(xbusStb), 32'h0);
        n = 0;
        while (rspValid !== 1'b1 && n < 50) begin
            held &= (xbusCyc === 1'b1);
            @(posedge clk);
            #1;
            n++;
        end
        check("xbusCyc held", 32'(held), 32'h1);
        check("xbusCyc end", 32'(xbusCyc), 32'h0);
        check("rspErr", 32'(rspErr), 32'(e));
        rd = rspData;
    endtask : bus
    // back-to-back transfers, slow and prompt answers, ack and error
    task automatic t_bus_seq();
        logic [31:0] rd;
        bus(1'b1, 32'h0000_0040, 32'hcafe_0123, 1'b0, 4'h0, rd);
        bus(1'b0, 32'h0000_0044, 32'h0, 1'b0, 4'h3, rd);
        check("rspData", rd, 32'hcafe_0123);
        bus(1'b1, 32'hffff_fffc, 32'h1111_2222, 1'b1, 4'h5, rd);
        bus(1'b0, 32'h0000_0000, 32'h0, 1'b0, 4'h0, rd);
        check("rspData", rd, 32'h1111_2222);
    endtask : t_bus_seq
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk);
        #1;
        check("rstnWdt", 32'(rstnWdt), 32'h0);
        @(posedge clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check("reqReady", 32'(reqReady), 32'h1);
        t_reset();
        t_chan();
        t_freeze();
        t_bus_seq();
        stop_test();
    end
endmodule : tb_spc_port_top
